// [core/hkcp_defs.vh]
// constants for the host key command parser
`ifndef HKCP_DEFS_VH
`define HKCP_DEFS_VH

// framing and control characters
`define HKCP_CHR_ESC        8'h1B
`define HKCP_CHR_CR         8'h0D
`define HKCP_CHR_CTRL_B     8'h02
`define HKCP_CHR_CTRL_P     8'h10
`define HKCP_CHR_ZERO       8'h30
`define HKCP_CHR_NINE       8'h39

// class letters
`define HKCP_CLS_KEY        8'h54
`define HKCP_CLS_OUT        8'h41
`define HKCP_CLS_SPC        8'h53

// four-digit codes, held as bcd
`define HKCP_CODE_CANCEL    16'h0100
`define HKCP_CODE_CONFIRM   16'h0104
`define HKCP_CODE_AXIS1     16'h0109
`define HKCP_CODE_AXIS2     16'h0110
`define HKCP_CODE_AXIS3     16'h0111
`define HKCP_CODE_LEFT      16'h0135
`define HKCP_CODE_RIGHT     16'h0136
`define HKCP_CODE_UP        16'h0137
`define HKCP_CODE_DOWN      16'h0138
`define HKCP_CODE_MENU      16'h0140
`define HKCP_CODE_UNIT      16'h0141
`define HKCP_CODE_ABSINC    16'h0142
`define HKCP_CODE_DIARAD    16'h0143
`define HKCP_CODE_HELP      16'h0144
`define HKCP_CODE_REFMARK   16'h0145
`define HKCP_CODE_OUT_ID    16'h0000
`define HKCP_CODE_OUT_POS   16'h0200
`define HKCP_CODE_SPC_RST   16'h0000
`define HKCP_CODE_SPC_LOCK  16'h0001
`define HKCP_CODE_SPC_FREE  16'h0002

// key identifiers on the key event port
`define HKCP_KEY_CANCEL     4'h0
`define HKCP_KEY_CONFIRM    4'h1
`define HKCP_KEY_AXIS1      4'h2
`define HKCP_KEY_AXIS2      4'h3
`define HKCP_KEY_AXIS3      4'h4
`define HKCP_KEY_LEFT       4'h5
`define HKCP_KEY_RIGHT      4'h6
`define HKCP_KEY_UP         4'h7
`define HKCP_KEY_DOWN       4'h8
`define HKCP_KEY_MENU       4'h9
`define HKCP_KEY_UNIT       4'hA
`define HKCP_KEY_ABSINC     4'hB
`define HKCP_KEY_DIARAD     4'hC
`define HKCP_KEY_HELP       4'hD
`define HKCP_KEY_REFMARK    4'hE

// frame shape and reset values
`define HKCP_CODE_DIGITS    3'h4
`define HKCP_LOCK_RESET     1'b0

`endif

// [core/hkcp_parser.v]
// host key command parser: frame decoder, key emulation and keypad lock
`timescale 1ns/10ps
`include "hkcp_defs.vh"

// Function
// - commands arrive as bytes from the usb data receiver on the rx port.
// - esc T code cr emulates the key that the code selects.
// - esc A code cr requests output of device identification or position values.
// - esc S code cr is a special-function command.
// - ctrl-b requests transmission of the current position.
// - ctrl-p requests transmission of a screen capture.
// - key 0100 is cancel, key 0104 is confirm.
// - keys 0109, 0110, 0111 are axis keys one, two, three.
// - keys 0135 and 0136 are left and right arrows.
// - keys 0137 and 0138 are up and down arrows.
// - key 0140 is menu, 0141 is the unit system toggle.
// - key 0142 toggles abs/inc, 0143 toggles diameter/radius.
// - key 0144 invokes help.
// - key 0145 enables reference mark evaluation.
// - output code 0000 sends device identification.
// - output code 0200 sends actual position values.
// - special code 0000 resets the device.
// - special code 0001 locks the physical keypad.
// - special code 0002 releases the physical keypad.
// - an axis zero key zeroes that axis at the present position.
module hkcp_parser (
  input  wire        I_SYS_CLK,
  input  wire        I_SYS_RST,
  input  wire        I_CE,
  input  wire [7:0]  I_RX_DATA,
  input  wire        I_RX_VALID,
  input  wire        I_PAD_STB,
  input  wire [3:0]  I_PAD_KEY_ID,
  output wire        O_KEY_STB,
  output wire [3:0]  O_KEY_ID,
  output wire        O_KEY_FROM_HOST,
  output wire [2:0]  O_AXIS_ZERO,
  output wire        O_SEND_ID,
  output wire        O_SEND_ACT_POS,
  output wire        O_SEND_CUR_POS,
  output wire        O_SEND_SCREEN,
  output wire        O_DEVICE_RESET,
  output wire        O_KEYPAD_LOCKED,
  output wire        O_FRAME_DROP
);

  ////////////////////////////////////////////////////////////////////////////
  // states
  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_CLASS = 2'b01;
  localparam [1:0] ST_CODE  = 2'b10;
  localparam [1:0] ST_END   = 2'b11;

  localparam [1:0] CLS_KEY  = 2'b00;
  localparam [1:0] CLS_OUT  = 2'b01;
  localparam [1:0] CLS_SPC  = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // key code lookup: {hit, key id}
  function [4:0] key_lookup;
    input [15:0] code;
    begin
      case (code)
        `HKCP_CODE_CANCEL:  key_lookup = {1'b1, `HKCP_KEY_CANCEL};
        `HKCP_CODE_CONFIRM: key_lookup = {1'b1, `HKCP_KEY_CONFIRM};
        `HKCP_CODE_AXIS1:   key_lookup = {1'b1, `HKCP_KEY_AXIS1};
        `HKCP_CODE_AXIS2:   key_lookup = {1'b1, `HKCP_KEY_AXIS2};
        `HKCP_CODE_AXIS3:   key_lookup = {1'b1, `HKCP_KEY_AXIS3};
        `HKCP_CODE_LEFT:    key_lookup = {1'b1, `HKCP_KEY_LEFT};
        `HKCP_CODE_RIGHT:   key_lookup = {1'b1, `HKCP_KEY_RIGHT};
        `HKCP_CODE_UP:      key_lookup = {1'b1, `HKCP_KEY_UP};
        `HKCP_CODE_DOWN:    key_lookup = {1'b1, `HKCP_KEY_DOWN};
        `HKCP_CODE_MENU:    key_lookup = {1'b1, `HKCP_KEY_MENU};
        `HKCP_CODE_UNIT:    key_lookup = {1'b1, `HKCP_KEY_UNIT};
        `HKCP_CODE_ABSINC:  key_lookup = {1'b1, `HKCP_KEY_ABSINC};
        `HKCP_CODE_DIARAD:  key_lookup = {1'b1, `HKCP_KEY_DIARAD};
        `HKCP_CODE_HELP:    key_lookup = {1'b1, `HKCP_KEY_HELP};
        `HKCP_CODE_REFMARK: key_lookup = {1'b1, `HKCP_KEY_REFMARK};
        default:            key_lookup = 5'h00;
      endcase
    end
  endfunction

  // axis key id to one-hot zero request
  function [2:0] axis_onehot;
    input [3:0] id;
    begin
      case (id)
        `HKCP_KEY_AXIS1: axis_onehot = 3'h1;
        `HKCP_KEY_AXIS2: axis_onehot = 3'h2;
        `HKCP_KEY_AXIS3: axis_onehot = 3'h4;
        default:         axis_onehot = 3'h0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg  [1:0]  state_q;
  reg  [1:0]  state_d;
  reg  [1:0]  cls_q;
  reg  [1:0]  cls_d;
  reg  [15:0] code_q;
  reg  [15:0] code_d;
  reg  [2:0]  cnt_q;
  reg  [2:0]  cnt_d;
  reg         lock_q;
  reg         lock_d;
  reg         key_stb_q;
  reg         key_stb_d;
  reg  [3:0]  key_id_q;
  reg  [3:0]  key_id_d;
  reg         key_host_q;
  reg         key_host_d;
  reg  [2:0]  axis_zero_q;
  reg  [2:0]  axis_zero_d;
  reg         send_id_q;
  reg         send_id_d;
  reg         send_act_q;
  reg         send_act_d;
  reg         send_cur_q;
  reg         send_cur_d;
  reg         send_scr_q;
  reg         send_scr_d;
  reg         dev_rst_q;
  reg         dev_rst_d;
  reg         drop_q;
  reg         drop_d;

  reg  [4:0]  lookup;
  reg         is_digit;
  reg         host_key;
  reg  [3:0]  host_id;

  ////////////////////////////////////////////////////////////////////////////
  // frame parser
  always @* begin
    state_d     = state_q;
    cls_d       = cls_q;
    code_d      = code_q;
    cnt_d       = cnt_q;
    lock_d      = lock_q;
    send_id_d   = 1'b0;
    send_act_d  = 1'b0;
    send_cur_d  = 1'b0;
    send_scr_d  = 1'b0;
    dev_rst_d   = 1'b0;
    drop_d      = 1'b0;
    host_key    = 1'b0;
    host_id     = 4'h0;
    lookup      = key_lookup(code_q);
    is_digit    = (I_RX_DATA >= `HKCP_CHR_ZERO) && (I_RX_DATA <= `HKCP_CHR_NINE);

    if (I_RX_VALID) begin
      if (I_RX_DATA == `HKCP_CHR_ESC) begin
        // a new escape always restarts, abandoning a partial frame
        drop_d  = (state_q != ST_IDLE);
        state_d = ST_CLASS;
        cnt_d   = 3'h0;
        code_d  = 16'h0000;
      end else if (I_RX_DATA == `HKCP_CHR_CTRL_B) begin
        send_cur_d = 1'b1;
        drop_d     = (state_q != ST_IDLE);
        state_d    = ST_IDLE;
      end else if (I_RX_DATA == `HKCP_CHR_CTRL_P) begin
        send_scr_d = 1'b1;
        drop_d     = (state_q != ST_IDLE);
        state_d    = ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            state_d = ST_IDLE;
          end
          ST_CLASS: begin
            if (I_RX_DATA == `HKCP_CLS_KEY) begin
              cls_d   = CLS_KEY;
              state_d = ST_CODE;
            end else if (I_RX_DATA == `HKCP_CLS_OUT) begin
              cls_d   = CLS_OUT;
              state_d = ST_CODE;
            end else if (I_RX_DATA == `HKCP_CLS_SPC) begin
              cls_d   = CLS_SPC;
              state_d = ST_CODE;
            end else begin
              drop_d  = 1'b1;
              state_d = ST_IDLE;
            end
          end
          ST_CODE: begin
            if (is_digit) begin
              code_d = {code_q[11:0], I_RX_DATA[3:0]};
              cnt_d  = cnt_q + 3'h1;
              if (cnt_q == `HKCP_CODE_DIGITS - 3'h1) begin
                state_d = ST_END;
              end
            end else begin
              drop_d  = 1'b1;
              state_d = ST_IDLE;
            end
          end
          ST_END: begin
            state_d = ST_IDLE;
            if (I_RX_DATA != `HKCP_CHR_CR) begin
              drop_d = 1'b1;
            end else begin
              case (cls_q)
                CLS_KEY: begin
                  host_key = lookup[4];
                  host_id  = lookup[3:0];
                  drop_d   = ~lookup[4];
                end
                CLS_OUT: begin
                  if (code_q == `HKCP_CODE_OUT_ID) begin
                    send_id_d = 1'b1;
                  end else if (code_q == `HKCP_CODE_OUT_POS) begin
                    send_act_d = 1'b1;
                  end else begin
                    drop_d = 1'b1;
                  end
                end
                CLS_SPC: begin
                  if (code_q == `HKCP_CODE_SPC_RST) begin
                    dev_rst_d = 1'b1;
                    lock_d    = `HKCP_LOCK_RESET;
                  end else if (code_q == `HKCP_CODE_SPC_LOCK) begin
                    lock_d = 1'b1;
                  end else if (code_q == `HKCP_CODE_SPC_FREE) begin
                    lock_d = 1'b0;
                  end else begin
                    drop_d = 1'b1;
                  end
                end
                default: begin
                  drop_d = 1'b1;
                end
              endcase
            end
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // key event merge
  // host key wins a same-cycle clash; the physical press is lost, which is
  // acceptable since the scanner repeats held keys
  always @* begin
    key_stb_d   = 1'b0;
    key_id_d    = key_id_q;
    key_host_d  = key_host_q;
    axis_zero_d = 3'h0;
    if (host_key) begin
      key_stb_d   = 1'b1;
      key_id_d    = host_id;
      key_host_d  = 1'b1;
      axis_zero_d = axis_onehot(host_id);
    end else if (I_PAD_STB && !lock_q) begin
      key_stb_d   = 1'b1;
      key_id_d    = I_PAD_KEY_ID;
      key_host_d  = 1'b0;
      axis_zero_d = axis_onehot(I_PAD_KEY_ID);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state update
  always @(posedge I_SYS_CLK) begin
    if (I_SYS_RST) begin
      state_q     <= ST_IDLE;
      cls_q       <= CLS_KEY;
      code_q      <= 16'h0000;
      cnt_q       <= 3'h0;
      lock_q      <= `HKCP_LOCK_RESET;
      key_stb_q   <= 1'b0;
      key_id_q    <= 4'h0;
      key_host_q  <= 1'b0;
      axis_zero_q <= 3'h0;
      send_id_q   <= 1'b0;
      send_act_q  <= 1'b0;
      send_cur_q  <= 1'b0;
      send_scr_q  <= 1'b0;
      dev_rst_q   <= 1'b0;
      drop_q      <= 1'b0;
    end else if (I_CE) begin
      state_q     <= state_d;
      cls_q       <= cls_d;
      code_q      <= code_d;
      cnt_q       <= cnt_d;
      lock_q      <= lock_d;
      key_stb_q   <= key_stb_d;
      key_id_q    <= key_id_d;
      key_host_q  <= key_host_d;
      axis_zero_q <= axis_zero_d;
      send_id_q   <= send_id_d;
      send_act_q  <= send_act_d;
      send_cur_q  <= send_cur_d;
      send_scr_q  <= send_scr_d;
      dev_rst_q   <= dev_rst_d;
      drop_q      <= drop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign O_KEY_STB       = key_stb_q;
  assign O_KEY_ID        = key_id_q;
  assign O_KEY_FROM_HOST = key_host_q;
  assign O_AXIS_ZERO     = axis_zero_q;
  assign O_SEND_ID       = send_id_q;
  assign O_SEND_ACT_POS  = send_act_q;
  assign O_SEND_CUR_POS  = send_cur_q;
  assign O_SEND_SCREEN   = send_scr_q;
  assign O_DEVICE_RESET  = dev_rst_q;
  assign O_KEYPAD_LOCKED = lock_q;
  assign O_FRAME_DROP    = drop_q;

endmodule

// [tb/hkcp_parser_props.sv]
// port assertions for the host key command parser
`timescale 1ns/10ps
`include "hkcp_defs.vh"
module hkcp_parser_props (
  input wire       I_SYS_CLK,
  input wire       I_SYS_RST,
  input wire       I_CE,
  input wire [7:0] I_RX_DATA,
  input wire       I_RX_VALID,
  input wire       I_PAD_STB,
  input wire [3:0] I_PAD_KEY_ID,
  input wire       O_KEY_STB,
  input wire [3:0] O_KEY_ID,
  input wire       O_KEY_FROM_HOST,
  input wire [2:0] O_AXIS_ZERO,
  input wire       O_SEND_ID,
  input wire       O_SEND_ACT_POS,
  input wire       O_SEND_CUR_POS,
  input wire       O_SEND_SCREEN,
  input wire       O_DEVICE_RESET,
  input wire       O_KEYPAD_LOCKED,
  input wire       O_FRAME_DROP
);
  wire rx_take = I_CE && I_RX_VALID;
  wire cr_take = rx_take && (I_RX_DATA == `HKCP_CHR_CR);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_cur; rx_take && I_RX_DATA == `HKCP_CHR_CTRL_B |=> O_SEND_CUR_POS; endproperty
  a_cur: assert property (p_cur) else $error("position send missing");
  property p_scr; rx_take && I_RX_DATA == `HKCP_CHR_CTRL_P |=> O_SEND_SCREEN; endproperty
  a_scr: assert property (p_scr) else $error("screen send missing");
  property p_axis; O_KEY_STB && O_KEY_ID >= 4'h2 && O_KEY_ID <= 4'h4 |-> O_AXIS_ZERO == (3'h1 << (O_KEY_ID - 4'h2));
  endproperty
  a_axis: assert property (p_axis) else $error("axis zero wrong");
  property p_zero; O_AXIS_ZERO != 3'h0 |-> O_KEY_STB; endproperty
  a_zero: assert property (p_zero) else $error("zero without key");
  property p_host; O_KEY_STB && O_KEY_FROM_HOST && $past(I_CE) |-> $past(cr_take); endproperty
  a_host: assert property (p_host) else $error("host key without cr");
  property p_lockd; I_CE && I_PAD_STB && O_KEYPAD_LOCKED |=> !O_KEY_STB || O_KEY_FROM_HOST; endproperty
  a_lockd: assert property (p_lockd) else $error("locked pad acted");
  property p_free;
    I_CE && I_PAD_STB && !O_KEYPAD_LOCKED |=> O_KEY_STB && (O_KEY_FROM_HOST || O_KEY_ID == $past(I_PAD_KEY_ID));
  endproperty
  a_free: assert property (p_free) else $error("pad key lost");
  property p_lchg; $changed(O_KEYPAD_LOCKED) |-> $past(I_SYS_RST) || $past(cr_take); endproperty
  a_lchg: assert property (p_lchg) else $error("lock changed alone");
  property p_rst; O_DEVICE_RESET |-> !O_KEYPAD_LOCKED; endproperty
  a_rst: assert property (p_rst) else $error("lock kept over reset");
  property p_drop; O_FRAME_DROP && $past(I_CE) |-> $past(rx_take); endproperty
  a_drop: assert property (p_drop) else $error("drop without byte");
endmodule

bind hkcp_parser hkcp_parser_props props_u (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE),
  .I_RX_DATA(I_RX_DATA), .I_RX_VALID(I_RX_VALID), .I_PAD_STB(I_PAD_STB), .I_PAD_KEY_ID(I_PAD_KEY_ID),
  .O_KEY_STB(O_KEY_STB), .O_KEY_ID(O_KEY_ID), .O_KEY_FROM_HOST(O_KEY_FROM_HOST), .O_AXIS_ZERO(O_AXIS_ZERO),
  .O_SEND_ID(O_SEND_ID), .O_SEND_ACT_POS(O_SEND_ACT_POS), .O_SEND_CUR_POS(O_SEND_CUR_POS),
  .O_SEND_SCREEN(O_SEND_SCREEN), .O_DEVICE_RESET(O_DEVICE_RESET), .O_KEYPAD_LOCKED(O_KEYPAD_LOCKED),
  .O_FRAME_DROP(O_FRAME_DROP));

// [tb/hkcp_host_model.sv]
// host application model sending command bytes
`timescale 1ns/10ps
`include "hkcp_defs.vh"
module hkcp_host_model (
  input  wire        i_clk,
  output logic [7:0] o_rx_data,
  output logic       o_rx_valid
);
  initial begin
    o_rx_data = 8'hA5;
    o_rx_valid = 1'b0;
  end
  // called at a falling edge, returns at the next one
  task put(input [7:0] b);
    o_rx_data = b;
    o_rx_valid = 1'b1;
    @(negedge i_clk);
  endtask
  // released data toggles so a stale byte never looks valid
  task idle(input int n);
    o_rx_valid = 1'b0;
    repeat (n) begin
      o_rx_data = ~o_rx_data;
      @(negedge i_clk);
    end
  endtask
  task send_frame(input [7:0] cls, input [15:0] code, input int tail);
    int i;
    put(`HKCP_CHR_ESC);
    put(cls);
    for (i = 3; i >= 0; i--) begin
      put(8'h30 + code[i*4 +: 4]);
    end
    put(`HKCP_CHR_CR);
    idle(tail);
  endtask
endmodule

// [tb/testbench.sv]
// self-checking testbench for the host key command parser
`timescale 1ns/10ps
module testbench;
  logic        I_SYS_CLK = 1'b0;
  logic        I_SYS_RST;
  logic        I_CE;
  logic        I_PAD_STB;
  logic [3:0]  I_PAD_KEY_ID;
  wire  [7:0]  I_RX_DATA;
  wire         I_RX_VALID;
  wire         O_KEY_STB;
  wire         O_KEY_FROM_HOST;
  wire         O_SEND_ID;
  wire         O_SEND_ACT_POS;
  wire         O_SEND_CUR_POS;
  wire         O_SEND_SCREEN;
  wire         O_DEVICE_RESET;
  wire         O_KEYPAD_LOCKED;
  wire         O_FRAME_DROP;
  wire  [3:0]  O_KEY_ID;
  wire  [2:0]  O_AXIS_ZERO;
  logic [14:0] exp_q[$];
  logic        ce_edge = 1'b0;
  int          num_errors = 0;
  int          check_count = 0;
  int          i, k, w;
  integer      seed = 75;
  logic [15:0] key_codes [0:14] = '{16'h0100, 16'h0104, 16'h0109, 16'h0110, 16'h0111, 16'h0135, 16'h0136,
    16'h0137, 16'h0138, 16'h0140, 16'h0141, 16'h0142, 16'h0143, 16'h0144, 16'h0145};
  logic [23:0] bad [0:5] = '{24'h580100, 24'h740100, 24'h540999, 24'h5401A0, 24'h410001, 24'h530003};
  wire  [14:0] seen_ev = {O_KEY_STB, O_KEY_STB ? {O_KEY_ID, O_KEY_FROM_HOST} : 5'h00, O_AXIS_ZERO,
    O_SEND_ID, O_SEND_ACT_POS, O_SEND_CUR_POS, O_SEND_SCREEN, O_DEVICE_RESET, O_FRAME_DROP};

  always #2.5 I_SYS_CLK = ~I_SYS_CLK;

  hkcp_host_model host_u (.i_clk(I_SYS_CLK), .o_rx_data(I_RX_DATA), .o_rx_valid(I_RX_VALID));

  hkcp_parser dut_u (.I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_RX_DATA(I_RX_DATA),
    .I_RX_VALID(I_RX_VALID), .I_PAD_STB(I_PAD_STB), .I_PAD_KEY_ID(I_PAD_KEY_ID), .O_KEY_STB(O_KEY_STB),
    .O_KEY_ID(O_KEY_ID), .O_KEY_FROM_HOST(O_KEY_FROM_HOST), .O_AXIS_ZERO(O_AXIS_ZERO), .O_SEND_ID(O_SEND_ID),
    .O_SEND_ACT_POS(O_SEND_ACT_POS), .O_SEND_CUR_POS(O_SEND_CUR_POS), .O_SEND_SCREEN(O_SEND_SCREEN),
    .O_DEVICE_RESET(O_DEVICE_RESET), .O_KEYPAD_LOCKED(O_KEYPAD_LOCKED), .O_FRAME_DROP(O_FRAME_DROP));

  ////////////////////////////////////////////////////////////////////////////
  function [14:0] key_ev(input [3:0] id, input host);
    key_ev = {1'b1, id, host, (id >= 4'h2 && id <= 4'h4) ? 3'h1 << (id - 4'h2) : 3'h0, 6'h00};
  endfunction
  task check_event(input [14:0] exp, input [14:0] got);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value event expected %h seen %h", exp, got);
    end
  endtask
  task check_lock(input exp);
    check_count++;
    if (O_KEYPAD_LOCKED !== exp) begin
      num_errors++;
      $display("wrong value keypad lock expected %b seen %b", exp, O_KEYPAD_LOCKED);
    end
  endtask
  task frame(input [7:0] cls, input [15:0] code, input [14:0] exp);
    if (exp !== 15'h0000) exp_q.push_back(exp);
    host_u.send_frame(cls, code, 2);
  endtask
  task pad(input [3:0] id);
    I_PAD_STB = 1'b1;
    I_PAD_KEY_ID = id;
    @(negedge I_SYS_CLK);
    I_PAD_STB = 1'b0;
    @(negedge I_SYS_CLK);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a pulse stretched by a low enable is taken only once
  always @(posedge I_SYS_CLK) ce_edge <= I_CE;
  always @(negedge I_SYS_CLK) begin
    if (!I_SYS_RST && ce_edge && seen_ev !== 15'h0000) begin
      check_event((exp_q.size() != 0) ? exp_q.pop_front() : 15'h0000, seen_ev);
    end
  end

  initial begin
    repeat (20000) @(posedge I_SYS_CLK);
    num_errors++;
    $display("wrong value run time expected done seen hung");
    stop_test;
  end

  initial begin
    I_SYS_RST = 1'b1;
    I_CE = 1'b1;
    I_PAD_STB = 1'b0;
    I_PAD_KEY_ID = 4'h0;
    repeat (12) @(negedge I_SYS_CLK);
    I_SYS_RST = 1'b0;
    for (i = 0; i < 15; i++) frame(8'h54, key_codes[i], key_ev(i[3:0], 1'b1));
    frame(8'h41, 16'h0000, 15'h0020);
    frame(8'h41, 16'h0200, 15'h0010);
    exp_q.push_back(15'h0008);
    host_u.put(8'h02);
    host_u.idle(2);
    exp_q.push_back(15'h0004);
    host_u.put(8'h10);
    host_u.idle(2);
    exp_q.push_back(15'h0009);
    host_u.put(8'h1B);
    host_u.put(8'h54);
    host_u.put(8'h30);
    host_u.put(8'h02);
    host_u.put(8'h41);
    host_u.idle(2);
    for (i = 0; i < 6; i++) frame(bad[i][23:16], bad[i][15:0], 15'h0001);
    frame(8'h53, 16'h0001, 15'h0000);
    check_lock(1'b1);
    k = $unsigned($random(seed)) % 15;
    pad(k[3:0]);
    frame(8'h54, 16'h0140, key_ev(4'h9, 1'b1));
    frame(8'h53, 16'h0002, 15'h0000);
    check_lock(1'b0);
    k = $unsigned($random(seed)) % 15;
    exp_q.push_back(key_ev(k[3:0], 1'b0));
    pad(k[3:0]);
    frame(8'h53, 16'h0001, 15'h0000);
    frame(8'h53, 16'h0000, 15'h0002);
    check_lock(1'b0);
    exp_q.push_back(key_ev(4'h2, 1'b1));
    host_u.send_frame(8'h54, 16'h0109, 0);
    I_CE = 1'b0;
    host_u.idle(3);
    I_CE = 1'b1;
    host_u.idle(1);
    // reset must clear the lock even with the enable low
    frame(8'h53, 16'h0001, 15'h0000);
    check_lock(1'b1);
    I_CE = 1'b0;
    I_SYS_RST = 1'b1;
    repeat (2) @(negedge I_SYS_CLK);
    I_SYS_RST = 1'b0;
    I_CE = 1'b1;
    check_lock(1'b0);
    for (i = 0; i < 20; i++) begin
      k = $unsigned($random(seed)) % 15;
      exp_q.push_back(key_ev(k[3:0], 1'b1));
      host_u.send_frame(8'h54, key_codes[k], 0);
    end
    host_u.idle(1);
    for (w = 0; w < 20 && exp_q.size() != 0; w++) @(negedge I_SYS_CLK);
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("wrong value pending events expected 0 seen %0d", exp_q.size());
    end
    stop_test;
  end
endmodule
